// ===== verilog/tx_subaddr_pingpong_status.sv
// Ping-pong selector, broadcast flag and ack handshake for one TX subaddress
// Notes on behaviour
// - Selector 0 picks data pointer A, 1 picks pointer B in ping-pong.
// - Selector inverts after each error-free, non-broadcast message while ping-pong enable and ack are high.
// - Selector kept after error, illegal command or Busy answer.
// - Master and software reset clear the selector to 0.
// - Selector is ignored in indexed and both circular modes.
// - Broadcast transmit command sets the broadcast-received flag.
// - With broadcast disabled, address 31 is not valid; flag unused.
// - Both resets clear the broadcast-received flag.
// - Ack rises once ping-pong enable is seen active.
// - Host sets stop request; device clears the ack.
// - Host clears stop request; device sets the ack again.
// - Enable high with ack low: fixed buffer, no toggle.
// - Circular mode 2 uses the trailing-zero count field.
// - Busy request: no data words and no selector toggle.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tx_subaddr_pingpong_status
  import tx_ctrl_pkg::*;
#(
  parameter int unsigned AW = 2
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic nrst_i, // Master reset, low
  input wire logic software_reset_cmd_i, // Software reset pulse
  input wire logic broadcast_disable_i, // Broadcast disable option
  input wire logic [AW-1:0] addr_i, // Register address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [15:0] rdata_o, // Read data
  input wire logic cmd_start_i, // TX command to this subaddress starts
  input wire logic [4:0] cmd_rt_addr_i, // Command terminal address
  input wire logic cmd_end_i, // Message complete pulse
  input wire logic cmd_error_i, // Message ended in error
  input wire logic cmd_illegal_i, // Command illegal
  input wire logic global_busy_i, // Terminal-wide busy status
  output logic use_ptr_b_o, // Fetch data pointer B
  output logic send_data_o, // Data words allowed
  output logic [3:0] circ2_trailing_zero_count_o, // Circ mode 2 count
  output logic [3:0] buf_mode_o, // One-hot buffer mode
  output logic irq_o // Interrupt level
);
  typedef struct packed {
    logic [15:0] cw;
    logic active;
    logic broadcast_received_flag_cmd;
    logic [15:0] rdata;
    logic [IRQ_W-1:0] mask;
    logic use_b;
    logic send;
    logic [3:0] czn;
    logic [3:0] mode;
    logic irq;
  } st_s;

  st_s s_q;
  st_s s_d;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] flags;
  logic stat_rd;

  function automatic buf_mode_e mode_of(input logic [15:0] cw);
    if (cw[BIT_PP_EN])
      return MODE_PINGPONG;
    else if (cw[BIT_CIRC2_EN])
      return MODE_CIRC2;
    else if (cw[BIT_CIRC1_EN])
      return MODE_CIRC1;
    else
      return MODE_INDEXED;
  endfunction

  function automatic logic is_broadcast_received_flag(input logic [4:0] a, input logic dis);
    return (a == BROADCAST_RECEIVED_FLAG_ADDR) && !dis;
  endfunction

  assign stat_rd = rd_i && (addr_i == ADDR_STATUS);

  always_comb
  begin
    logic busy;
    logic pp;
    logic good;
    logic [15:0] hw_bits;
    logic [15:0] wmask;
    busy = 1'b0;
    pp = 1'b0;
    good = 1'b0;
    hw_bits = '0;
    wmask = '0;
    s_d = s_q;
    ev = '0;
    busy = s_q.cw[BIT_BUSY_REQ] || global_busy_i;
    pp = (mode_of(s_q.cw) == MODE_PINGPONG);
    // Host writes keep device-owned bits
    wmask = 16'hffff;
    wmask[BIT_SELECTOR] = 1'b0;
    wmask[BIT_BROADCAST_RECEIVED_FLAG] = 1'b0;
    wmask[BIT_PP_ACK] = 1'b0;
    if (wr_i && addr_i == ADDR_CTRL)
    begin
      s_d.cw = (wdata_i & wmask) | (s_q.cw & ~wmask);
    end
    if (wr_i && addr_i == ADDR_IRQ_MASK)
    begin
      s_d.mask = wdata_i[IRQ_W-1:0];
    end
    // Command start latches buffer choice
    if (cmd_start_i && !s_q.active)
    begin
      s_d.active = 1'b1;
      s_d.broadcast_received_flag_cmd = is_broadcast_received_flag(cmd_rt_addr_i, broadcast_disable_i);
      // Selector only matters in ping-pong
      s_d.use_b = pp && s_q.cw[BIT_SELECTOR];
      s_d.send = !busy;
      s_d.czn = s_q.cw[CZN_HI:CZN_LO];
      if (is_broadcast_received_flag(cmd_rt_addr_i, broadcast_disable_i))
      begin
        s_d.cw[BIT_BROADCAST_RECEIVED_FLAG] = 1'b1;
        ev[IRQ_BROADCAST_RECEIVED_FLAG] = 1'b1;
      end
    end
    if (cmd_end_i && s_q.active)
    begin
      s_d.active = 1'b0;
      s_d.send = 1'b0;
      good = !cmd_error_i && !cmd_illegal_i && !busy && !s_q.broadcast_received_flag_cmd;
      // Toggle only with ack high
      if (pp && s_q.cw[BIT_PP_ACK] && good)
      begin
        s_d.cw[BIT_SELECTOR] = !s_q.cw[BIT_SELECTOR];
        ev[IRQ_TOGGLE] = 1'b1;
      end
    end
    // Handshake only between messages
    if (!s_q.active && !cmd_start_i)
    begin
      if (pp && !s_q.cw[BIT_STOP_REQ] && !s_q.cw[BIT_PP_ACK])
      begin
        s_d.cw[BIT_PP_ACK] = 1'b1;
        ev[IRQ_ACK_CHG] = 1'b1;
      end
      else if (s_q.cw[BIT_PP_ACK] && (!pp || s_q.cw[BIT_STOP_REQ]))
      begin
        s_d.cw[BIT_PP_ACK] = 1'b0;
        ev[IRQ_ACK_CHG] = 1'b1;
      end
    end
    s_d.mode = mode_of(s_q.cw);
    hw_bits = s_q.cw;
    s_d.rdata = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_CTRL: s_d.rdata = hw_bits;
        ADDR_STATUS: s_d.rdata = {{(16-IRQ_W){1'b0}}, flags};
        ADDR_IRQ_MASK: s_d.rdata = {{(16-IRQ_W){1'b0}}, s_q.mask};
        ADDR_ACTIVE: s_d.rdata = {15'h0000, s_q.active};
      endcase
    end
    s_d.irq = |((flags | ev) & s_d.mask) && !stat_rd
      || |(ev & s_d.mask);
    if (!nrst_i)
    begin
      s_d = '0;
      s_d.cw = CW_RESET;
      s_d.mode = MODE_INDEXED;
    end
    else if (software_reset_cmd_i)
    begin
      s_d.cw[BIT_SELECTOR] = 1'b0;
      s_d.cw[BIT_BROADCAST_RECEIVED_FLAG] = 1'b0;
      s_d.active = 1'b0;
      s_d.send = 1'b0;
      s_d.use_b = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    s_q <= s_d;
  end

  edge_flag #(
    .W(IRQ_W)
  ) u_flags (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .set_i(ev),
    .clr_i(stat_rd),
    .flag_o(flags)
  );

  assign rdata_o = s_q.rdata;
  assign use_ptr_b_o = s_q.use_b;
  assign send_data_o = s_q.send;
  assign circ2_trailing_zero_count_o = s_q.czn;
  assign buf_mode_o = s_q.mode;
  assign irq_o = s_q.irq;
endmodule
`default_nettype wire

// ===== verilog/tx_ctrl_pkg.sv
// Constants for the transmit subaddress control word status logic
package tx_ctrl_pkg;
  localparam int unsigned CW_WIDTH = 16;
  localparam int unsigned BIT_BUSY_REQ = 12;
  localparam int unsigned BIT_SELECTOR = 10;
  localparam int unsigned BIT_BROADCAST_RECEIVED_FLAG = 9;
  localparam int unsigned BIT_PP_ACK = 8;
  localparam int unsigned CZN_HI = 7;
  localparam int unsigned CZN_LO = 4;
  localparam int unsigned BIT_STOP_REQ = 3;
  localparam int unsigned BIT_PP_EN = 2;
  localparam int unsigned BIT_CIRC2_EN = 1;
  localparam int unsigned BIT_CIRC1_EN = 0;
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [4:0] BROADCAST_RECEIVED_FLAG_ADDR = 5'h1f;
  // Register offsets on the plain port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;
  localparam logic [1:0] ADDR_ACTIVE = 2'h3;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_TOGGLE = 0;
  localparam int unsigned IRQ_BROADCAST_RECEIVED_FLAG = 1;
  localparam int unsigned IRQ_ACK_CHG = 2;
  typedef enum logic [3:0] {
    MODE_INDEXED = 4'h1,
    MODE_CIRC1 = 4'h2,
    MODE_CIRC2 = 4'h4,
    MODE_PINGPONG = 4'h8
  } buf_mode_e;
endpackage

// ===== verilog/edge_flag.sv
// Sticky event flag with read clear where a new set wins
`timescale 1ns/10ps
`default_nettype none
module edge_flag #(
  parameter int unsigned W = 3
) (
  input wire logic ref_clk_i, // Clock
  input wire logic nrst_i, // Sync reset, low
  input wire logic [W-1:0] set_i, // Event pulses
  input wire logic clr_i, // Read clear
  output logic [W-1:0] flag_o // Sticky flags
);
  typedef struct packed {
    logic [W-1:0] flag;
  } st_s;
  st_s s_q;
  st_s s_d;
  always_comb
  begin
    s_d = s_q;
    if (clr_i)
    begin
      s_d.flag = '0;
    end
    s_d.flag = s_d.flag | set_i;
    if (!nrst_i)
    begin
      s_d.flag = '0;
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    s_q <= s_d;
  end
  assign flag_o = s_q.flag;
endmodule
`default_nettype wire

// ===== testbench/tx_pp_asserts.sv
// Port checks for the TX subaddress status block
`timescale 1ns/10ps
`default_nettype none
module tx_pp_asserts
  import tx_ctrl_pkg::*;
#(
  parameter int unsigned AW = 2
) (
  input wire logic ref_clk_i, // In
  input wire logic nrst_i, // In
  input wire logic software_reset_cmd_i, // In
  input wire logic [AW-1:0] addr_i, // In
  input wire logic [15:0] wdata_i, // In
  input wire logic wr_i, // In
  input wire logic cmd_start_i, // In
  input wire logic cmd_end_i, // In
  input wire logic global_busy_i, // In
  input wire logic use_ptr_b_o, // In
  input wire logic send_data_o, // In
  input wire logic [3:0] circ2_trailing_zero_count_o, // In
  input wire logic [3:0] buf_mode_o // In
);
  logic act_q, bsy_q, tk;
  logic [3:0] czn_q;
  assign tk = cmd_start_i && !act_q && !software_reset_cmd_i;
  always_ff @(posedge ref_clk_i)
    if (!nrst_i || software_reset_cmd_i)
      act_q <= 1'b0;
    else
      act_q <= act_q ? !cmd_end_i : cmd_start_i;
  // Shadow of the busy bit and zero count
  always_ff @(posedge ref_clk_i)
    if (!nrst_i)
      {bsy_q, czn_q} <= 5'h00;
    else if (wr_i && addr_i == ADDR_CTRL)
      {bsy_q, czn_q} <= {wdata_i[12], wdata_i[7:4]};
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  AST_RESET: assert property ($rose(nrst_i) |->
    buf_mode_o == 4'h1 && !use_ptr_b_o) else $error("reset");
  AST_MODE_PP: assert property (wr_i && addr_i == ADDR_CTRL &&
    wdata_i[2] |-> ##2 buf_mode_o == 4'h8) else $error("mode");
  AST_PTR_MODE: assert property (tk && !$past(wr_i) &&
    buf_mode_o != 4'h8 |=> !use_ptr_b_o) else $error("ptr mode");
  AST_PTR_HOLD: assert property (act_q && !cmd_end_i &&
    !software_reset_cmd_i |=> $stable(use_ptr_b_o)) else $error("ptr");
  AST_SEND_BUSY: assert property (tk && global_busy_i |=>
    !send_data_o) else $error("busy send");
  AST_SEND_ON: assert property (tk && !global_busy_i && !bsy_q |=>
    send_data_o) else $error("no send");
  AST_SEND_END: assert property (act_q && cmd_end_i |=>
    !send_data_o) else $error("send end");
  AST_CZN: assert property (tk && !wr_i |=>
    circ2_trailing_zero_count_o == czn_q) else $error("count");
endmodule
bind tx_subaddr_pingpong_status tx_pp_asserts #(.AW(AW)) chk_i (.*);
`default_nettype wire

// ===== testbench/tx_host_model.sv
// Host model on the register port
`timescale 1ns/10ps
`default_nettype none
module tx_host_model (
  input wire logic clk_i, // Clock
  input wire logic [15:0] rdata_i, // Read data
  output logic [1:0] addr_o, // Address
  output logic [15:0] wdata_o, // Write data
  output logic wr_o, // Write
  output logic rd_o // Read
);
  initial {addr_o, wdata_o, wr_o, rd_o} = 20'h0_0000;
  task put(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d & 16'hFEFF;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task get(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tx_subaddr_pingpong_status_tb.sv
// Bench for the TX subaddress status block
`timescale 1ns/10ps
`default_nettype none
module tx_subaddr_pingpong_status_tb;
  import tx_ctrl_pkg::*;
  logic clk = 0, nrst = 0, swr = 0, bd = 0, st = 0, en = 0, er = 0;
  logic gb = 0, il = 0, wr, rd, pb, sd, irq;
  logic [4:0] rt = 5'h01;
  logic [1:0] ad;
  logic [15:0] wd, rq, v;
  logic [3:0] cz, bm;
  int bad_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  tx_host_model host (.clk_i(clk), .rdata_i(rq), .addr_o(ad),
    .wdata_o(wd), .wr_o(wr), .rd_o(rd));
  tx_subaddr_pingpong_status uut (.ref_clk_i(clk), .nrst_i(nrst),
    .software_reset_cmd_i(swr), .broadcast_disable_i(bd), .addr_i(ad),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rq), .cmd_start_i(st),
    .cmd_rt_addr_i(rt), .cmd_end_i(en), .cmd_error_i(er),
    .cmd_illegal_i(il), .global_busy_i(gb), .use_ptr_b_o(pb),
    .send_data_o(sd), .circ2_trailing_zero_count_o(cz), .buf_mode_o(bm),
    .irq_o(irq));
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task rc(input logic [1:0] a, input logic [15:0] e);
    host.get(a, v);
    chk(v, e);
  endtask
  task msg(input logic [4:0] a, input logic e, input logic p);
    @(posedge clk);
    st <= 1'b1;
    rt <= a;
    @(posedge clk);
    st <= 1'b0;
    #1;
    chk(16'({sd, pb}), 16'({~gb, p}));
    @(posedge clk);
    en <= 1'b1;
    er <= e;
    @(posedge clk);
    en <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task give_verdict;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rc(ADDR_CTRL, 16'h0000);
    host.put(ADDR_IRQ_MASK, 16'h0007);
    host.put(ADDR_CTRL, 16'h0004);
    rc(ADDR_CTRL, 16'h0104);
    repeat (2) @(negedge clk);
    chk(16'(irq), 16'h0001);
    rc(ADDR_STATUS, 16'h0004);
    repeat (3) @(negedge clk);
    chk(16'(irq), 16'h0000);
    msg(5'h01, 1'b0, 1'b0);
    rc(ADDR_CTRL, 16'h0504);
    msg(5'h01, 1'b1, 1'b1);
    rc(ADDR_CTRL, 16'h0504);
    il <= 1'b1;
    msg(5'h01, 1'b0, 1'b1);
    il <= 1'b0;
    rc(ADDR_CTRL, 16'h0504);
    host.put(ADDR_CTRL, 16'h000C);
    rc(ADDR_CTRL, 16'h040C);
    msg(5'h01, 1'b0, 1'b1);
    rc(ADDR_CTRL, 16'h040C);
    host.put(ADDR_CTRL, 16'h0004);
    rc(ADDR_CTRL, 16'h0504);
    gb <= 1'b1;
    msg(5'h01, 1'b0, 1'b1);
    gb <= 1'b0;
    rc(ADDR_CTRL, 16'h0504);
    bd <= 1'b1;
    msg(5'h1F, 1'b1, 1'b1);
    rc(ADDR_CTRL, 16'h0504);
    bd <= 1'b0;
    msg(5'h1F, 1'b0, 1'b1);
    rc(ADDR_CTRL, 16'h0704);
    swr <= 1'b1;
    @(posedge clk);
    swr <= 1'b0;
    rc(ADDR_CTRL, 16'h0104);
    msg(5'h01, 1'b0, 1'b0);
    host.put(ADDR_CTRL, 16'h0052);
    msg(5'h01, 1'b0, 1'b0);
    chk(16'(cz), 16'h0005);
    chk(16'(bm), 16'h0004);
    host.put(ADDR_CTRL, 16'h0001);
    repeat (2) @(negedge clk);
    chk(16'(bm), 16'h0002);
    host.put(ADDR_IRQ_MASK, 16'h0000);
    repeat (3) @(negedge clk);
    chk(16'(irq), 16'h0000);
    give_verdict;
  end
  initial
  begin
    #100000;
    bad_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
